// *** design/sic_ctrl.v ***
`timescale 1ns/1ns
`include "sic_defs.vh"
module sic_ctrl
#(
	parameter EDGE_SELECT_EN = 1
)
(
	input  wire       core_clk,
	input  wire       rst_b,
	input  wire [5:0] int_req,
	input  wire       first_edge_pin,
	input  wire       second_edge_pin,
	input  wire       fetch_sample,
	input  wire       enable_interrupts_op,
	input  wire       disable_interrupts_op,
	input  wire       interrupt_return_op,
	input  wire       prio_wr,
	input  wire       mask_wr,
	input  wire       flags_wr,
	input  wire [7:0] wr_data,
	input  wire       ack_step,
	output reg  [7:0] interrupt_enable_mask,
	output reg  [7:0] interrupt_request_flags,
	output reg        int_pending,
	output reg        ack_busy,
	output reg  [2:0] ack_phase,
	output reg  [2:0] serviced_level,
	output reg  [3:0] vector_addr_hi,
	output reg  [3:0] vector_addr_lo
);
	reg [7:0] prio_q;
	reg [5:0] latch_q;
	reg       armed_q;
	reg [4:0] ack_cnt_q;
	reg [1:0] step_q;
	reg       pend_d;
	reg [2:0] win_d;
	reg [5:0] new_lat;
	reg [5:0] flags_d;
	wire      pulse_a;
	wire      pulse_b;
	wire [5:0] eligible;
	wire [5:0] hw_req;
	wire       do_sample;

	sic_pin_edge u_edge_a
	(
		.core_clk   (core_clk),
		.rst_b      (rst_b),
		.pin_in     (first_edge_pin),
		.edge_sel   ({interrupt_request_flags[`SIC_EDGE_HI_BIT] & interrupt_request_flags[`SIC_EDGE_LO_BIT],
			interrupt_request_flags[`SIC_EDGE_HI_BIT] & ~interrupt_request_flags[`SIC_EDGE_LO_BIT]}),
		.edge_pulse (pulse_a)
	);

	sic_pin_edge u_edge_b
	(
		.core_clk   (core_clk),
		.rst_b      (rst_b),
		.pin_in     (second_edge_pin),
		.edge_sel   ({1'b0, interrupt_request_flags[`SIC_EDGE_LO_BIT]} |
			{interrupt_request_flags[`SIC_EDGE_HI_BIT] & interrupt_request_flags[`SIC_EDGE_LO_BIT], 1'b0}),
		.edge_pulse (pulse_b)
	);

	// Pins feed levels 2 and 0; internal sources are ORed in
	assign hw_req = int_req | {3'h0, pulse_a, 1'b0, pulse_b};

	assign eligible = interrupt_request_flags[5:0] & interrupt_enable_mask[5:0] &
		{6{interrupt_enable_mask[`SIC_MASTER_BIT]}};

	assign do_sample = fetch_sample & ~ack_busy;

	function [2:0] grp_pick;
		input [1:0] grp;
		input [5:0] el;
		input [7:0] pr;
		reg   [2:0] hi;
		reg   [2:0] lo;
		begin
			hi = 3'd0;
			lo = 3'd0;
			case (grp)
				2'd0:
				begin
					hi = pr[5] ? 3'd3 : 3'd5;
					lo = pr[5] ? 3'd5 : 3'd3;
				end
				2'd1:
				begin
					hi = pr[2] ? 3'd0 : 3'd2;
					lo = pr[2] ? 3'd2 : 3'd0;
				end
				default:
				begin
					hi = pr[1] ? 3'd4 : 3'd1;
					lo = pr[1] ? 3'd1 : 3'd4;
				end
			endcase
			grp_pick = el[hi] ? hi : lo;
		end
	endfunction

	function grp_any;
		input [1:0] grp;
		input [5:0] el;
		begin
			case (grp)
				2'd0:    grp_any = el[3] | el[5];
				2'd1:    grp_any = el[0] | el[2];
				default: grp_any = el[1] | el[4];
			endcase
		end
	endfunction

	// Group order codes: 0=A 1=B 2=C
	reg [5:0] order;
	integer   g;
	always @*
	begin
		order  = 6'h0;
		pend_d = 1'b0;
		win_d  = 3'd0;
		case ({prio_q[4], prio_q[3], prio_q[0]})
			3'b001:  order = {2'd2, 2'd0, 2'd1};
			3'b010:  order = {2'd0, 2'd1, 2'd2};
			3'b011:  order = {2'd0, 2'd2, 2'd1};
			3'b100:  order = {2'd1, 2'd2, 2'd0};
			3'b101:  order = {2'd2, 2'd1, 2'd0};
			3'b110:  order = {2'd1, 2'd0, 2'd2};
			default: order = {2'd0, 2'd1, 2'd2};
		endcase
		for (g = 0; g < 3; g = g + 1)
		begin
			if (!pend_d && grp_any(order[5-2*g -: 2], eligible))
			begin
				pend_d = 1'b1;
				win_d  = grp_pick(order[5-2*g -: 2], eligible, prio_q);
			end
		end
	end

	always @*
	begin
		new_lat = latch_q | hw_req;
		flags_d = interrupt_request_flags[5:0];
		if (do_sample)
			flags_d = flags_d | latch_q;
		if (flags_wr && armed_q)
			flags_d = wr_data[5:0] | (do_sample ? latch_q : 6'h0);
	end

	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			prio_q                  <= 8'h00;
			interrupt_enable_mask   <= 8'h00;
			interrupt_request_flags <= 8'h00;
			latch_q                 <= 6'h00;
			armed_q                 <= 1'b0;
			int_pending             <= 1'b0;
			ack_busy                <= 1'b0;
			ack_phase               <= `SIC_ST_IDLE;
			ack_cnt_q               <= 5'h0;
			step_q                  <= 2'h0;
			serviced_level          <= 3'd0;
			vector_addr_hi          <= 4'h0;
			vector_addr_lo          <= 4'h0;
		end
		else
		begin
			int_pending <= pend_d & ~ack_busy;
			if (enable_interrupts_op)
				armed_q <= 1'b1;
			if (prio_wr)
				prio_q <= wr_data;
			if (armed_q)
				latch_q <= do_sample ? hw_req : new_lat;
			interrupt_request_flags[5:0] <= armed_q ? flags_d : 6'h00;
			if (EDGE_SELECT_EN != 0 && flags_wr && armed_q)
				interrupt_request_flags[7:6] <= wr_data[7:6];
			else if (EDGE_SELECT_EN == 0)
				interrupt_request_flags[7:6] <= 2'h0;
			if (mask_wr)
				interrupt_enable_mask <= wr_data;
			if (enable_interrupts_op)
				interrupt_enable_mask[`SIC_MASTER_BIT] <= 1'b1;
			else if (disable_interrupts_op)
				interrupt_enable_mask[`SIC_MASTER_BIT] <= 1'b0;
			else if (interrupt_return_op)
				interrupt_enable_mask[`SIC_MASTER_BIT] <= 1'b1;
			if (!ack_busy && do_sample && pend_d)
			begin
				ack_busy                                <= 1'b1;
				ack_cnt_q                               <= 5'h0;
				step_q                                  <= 2'h0;
				ack_phase                               <= `SIC_ST_PUSH_PCL;
				serviced_level                          <= win_d;
				vector_addr_hi                          <= {win_d, 1'b0};
				vector_addr_lo                          <= {win_d, 1'b1};
				interrupt_enable_mask[`SIC_MASTER_BIT]  <= 1'b0;
				interrupt_request_flags[win_d]          <= 1'b0;
			end
			else if (ack_busy)
			begin
				ack_cnt_q <= ack_cnt_q + 5'h1;
				if (ack_step)
					step_q <= step_q + 2'h1;
				if (ack_cnt_q == `SIC_ACK_CYCLES - 1)
				begin
					ack_busy  <= 1'b0;
					ack_phase <= `SIC_ST_IDLE;
				end
				else if (ack_cnt_q[1:0] == 2'h3)
				begin
					case (ack_phase)
						`SIC_ST_PUSH_PCL: ack_phase <= `SIC_ST_PUSH_PCH;
						`SIC_ST_PUSH_PCH: ack_phase <= `SIC_ST_PUSH_FLG;
						`SIC_ST_PUSH_FLG: ack_phase <= `SIC_ST_FETCH_VH;
						`SIC_ST_FETCH_VH: ack_phase <= `SIC_ST_FETCH_VL;
						`SIC_ST_FETCH_VL: ack_phase <= `SIC_ST_BRANCH;
						default:          ack_phase <= ack_phase;
					endcase
				end
			end
		end
	end
endmodule // sic_ctrl

// *** design/sic_defs.vh ***
`ifndef SIC_DEFS_VH
`define SIC_DEFS_VH
`define SIC_LEVELS       6
`define SIC_MASTER_BIT   7
`define SIC_EDGE_HI_BIT  7
`define SIC_EDGE_LO_BIT  6
`define SIC_ACK_CYCLES   24
`define SIC_SYNC_STAGES  2
`define SIC_ST_IDLE      3'h0
`define SIC_ST_PUSH_PCL  3'h1
`define SIC_ST_PUSH_PCH  3'h2
`define SIC_ST_PUSH_FLG  3'h3
`define SIC_ST_FETCH_VH  3'h4
`define SIC_ST_FETCH_VL  3'h5
`define SIC_ST_BRANCH    3'h6
`endif

// *** design/sic_pin_edge.v ***
`timescale 1ns/1ns
`include "sic_defs.vh"
module sic_pin_edge
(
	input  wire       core_clk,
	input  wire       rst_b,
	input  wire       pin_in,
	input  wire [1:0] edge_sel,
	output reg        edge_pulse
);
	reg [`SIC_SYNC_STAGES-1:0] sync_q;
	reg                        prev_q;
	reg [2:0]                  fill_q;
	wire                       rise;
	wire                       fall;

	// Edges stay masked until both sync flops and prev_q hold real pin samples,
	// so the pin's idle level after reset never looks like a transition
	assign rise = fill_q[2] & sync_q[1] & ~prev_q;
	assign fall = fill_q[2] & ~sync_q[1] & prev_q;

	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync_q     <= 2'h0;
			prev_q     <= 1'b0;
			fill_q     <= 3'h0;
			edge_pulse <= 1'b0;
		end
		else
		begin
			fill_q     <= {fill_q[1:0], 1'b1};
			sync_q     <= {sync_q[0], pin_in};
			prev_q     <= sync_q[1];
			case (edge_sel)
				2'h0:    edge_pulse <= fall;
				2'h1:    edge_pulse <= rise;
				2'h2:    edge_pulse <= rise | fall;
				default: edge_pulse <= rise | fall;
			endcase
		end
	end
endmodule // sic_pin_edge

// *** verif/sic_ctrl_monitor.sv ***
`timescale 1ns/1ns
module sic_ctrl_monitor
(
	input wire       core_clk,
	input wire       rst_b,
	input wire       fetch_sample,
	input wire       enable_interrupts_op,
	input wire       disable_interrupts_op,
	input wire       interrupt_return_op,
	input wire [7:0] interrupt_enable_mask,
	input wire [7:0] interrupt_request_flags,
	input wire       int_pending,
	input wire       ack_busy,
	input wire [2:0] ack_phase,
	input wire [2:0] serviced_level,
	input wire [3:0] vector_addr_hi,
	input wire [3:0] vector_addr_lo
);
	reg armed_q;
	always @(posedge core_clk or negedge rst_b)
		if (!rst_b)
			armed_q <= 1'b0;
		else if (enable_interrupts_op)
			armed_q <= 1'b1;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	sequence ph_s(int n);
		(ack_phase == n) [*4];
	endsequence
	ack_start_a: assert property (fetch_sample && !ack_busy && interrupt_enable_mask[7] &&
		(interrupt_request_flags[5:0] & interrupt_enable_mask[5:0]) != 6'h00 |=> ack_busy &&
		!interrupt_enable_mask[7] && !interrupt_request_flags[serviced_level]) else $error("ack start wrong");
	ack_steps_a: assert property ($rose(ack_busy) |-> ph_s(1) ##1 ph_s(2) ##1 ph_s(3) ##1 ph_s(4)
		##1 ph_s(5) ##1 ph_s(6) ##1 !ack_busy) else $error("ack steps wrong");
	vec_pair_a: assert property (ack_busy |-> vector_addr_hi == {serviced_level, 1'b0} &&
		vector_addr_lo == {serviced_level, 1'b1}) else $error("vector pair wrong");
	ei_sets_a: assert property (enable_interrupts_op && !fetch_sample |=> interrupt_enable_mask[7])
		else $error("enable op failed");
	di_clears_a: assert property (disable_interrupts_op && !enable_interrupts_op |=> !interrupt_enable_mask[7])
		else $error("disable op failed");
	ret_sets_a: assert property (interrupt_return_op && !disable_interrupts_op && !enable_interrupts_op
		&& !fetch_sample |=> interrupt_enable_mask[7]) else $error("return op failed");
	flags_held_a: assert property (!armed_q |-> interrupt_request_flags == 8'h00)
		else $error("flags not held");
	pend_gate_a: assert property (int_pending |-> interrupt_enable_mask[7] || $past(interrupt_enable_mask[7]))
		else $error("pending while disabled");
endmodule // sic_ctrl_monitor
bind sic_ctrl sic_ctrl_monitor mon (.*);

// *** verif/sic_core_model.sv ***
`timescale 1ns/1ns
module sic_core_model
(
	input wire  core_clk,
	input wire  rst_b,
	input wire  fetch_req,
	input wire  ack_busy,
	output reg  fetch_sample,
	output reg  ack_step
);
	// No opcode fetch while the acknowledge sequence owns the core
	always @(posedge core_clk or negedge rst_b)
		if (!rst_b)
		begin
			fetch_sample <= 1'b0;
			ack_step <= 1'b0;
		end
		else
		begin
			fetch_sample <= fetch_req && !ack_busy;
			ack_step <= ack_busy;
		end
endmodule // sic_core_model

// *** verif/six_level_interrupt_controller_tb.sv ***
`timescale 1ns/1ns
module six_level_interrupt_controller_tb;
	localparam [6:0] S_EI = 7'h01, S_DI = 7'h02, S_RET = 7'h04, S_PR = 7'h08, S_MK = 7'h10, S_FL = 7'h20, S_FE = 7'h40;
	reg        core_clk = 1'b0;
	reg        rst_b = 1'b0;
	reg  [5:0] int_req = 6'h00;
	reg        pin_a = 1'b1;
	reg        pin_b = 1'b1;
	reg  [6:0] stb = 7'h00;
	reg  [7:0] wdat = 8'h00;
	reg  [7:0] p;
	wire       fetch_sample, ack_step, int_pending, ack_busy;
	wire [7:0] mask, flags;
	wire [2:0] phase, lvl;
	wire [3:0] vh, vl;
	integer    err_count = 0;
	integer    n_checks = 0;
	integer    i, k;
	always #2 core_clk = ~core_clk;
	sic_core_model core (.core_clk(core_clk), .rst_b(rst_b), .fetch_req(stb[6]), .ack_busy(ack_busy),
		.fetch_sample(fetch_sample), .ack_step(ack_step));
	sic_ctrl dut (.core_clk(core_clk), .rst_b(rst_b), .int_req(int_req), .first_edge_pin(pin_a),
		.second_edge_pin(pin_b), .fetch_sample(fetch_sample), .enable_interrupts_op(stb[0]),
		.disable_interrupts_op(stb[1]), .interrupt_return_op(stb[2]), .prio_wr(stb[3]), .mask_wr(stb[4]),
		.flags_wr(stb[5]), .wr_data(wdat), .ack_step(ack_step), .interrupt_enable_mask(mask),
		.interrupt_request_flags(flags), .int_pending(int_pending), .ack_busy(ack_busy), .ack_phase(phase),
		.serviced_level(lvl), .vector_addr_hi(vh), .vector_addr_lo(vl));
	function [2:0] win(input [7:0] q);
	begin
		case ({q[4], q[3], q[0]})
			3'b010, 3'b011: win = q[5] ? 3'h3 : 3'h5;
			3'b100, 3'b110: win = q[2] ? 3'h0 : 3'h2;
			default: win = q[1] ? 3'h4 : 3'h1;
		endcase
	end
	endfunction
	task test_done;
	begin
		if (err_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	task chk(input [7:0] got, input [7:0] exp);
	begin
		n_checks = n_checks + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task op(input [6:0] s, input [7:0] d);
	begin
		@(posedge core_clk);
		stb <= s;
		wdat <= d;
		@(posedge core_clk);
		stb <= 7'h00;
		#1;
	end
	endtask
	// Edge bits are rewritten by any flags write once an enable op has armed the controller
	task pin_case(input [7:0] sel, input v, input [7:0] exp);
	begin
		op(S_FL, sel);
		@(posedge core_clk);
		pin_a <= v;
		pin_b <= v;
		repeat (5) @(posedge core_clk);
		op(S_FE, 8'h00);
		@(posedge core_clk) #1;
		chk(flags, exp);
	end
	endtask
	// Bounded wait for ack_busy to reach the requested value (start or end of acknowledge); a hang ends the run
	task wait_busy(input v);
	begin
		for (k = 0; k < 40 && ack_busy !== v; k = k + 1)
			@(posedge core_clk) #1;
		if (ack_busy !== v)
		begin
			err_count = err_count + 1;
			test_done;
		end
	end
	endtask
	initial
	begin
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		#1;
		chk(mask & 8'h80, 8'h00);
		chk(flags, 8'h00);
		op(S_MK, 8'h80);
		op(S_FL, 8'h3f);
		chk(flags, 8'h00);
		op(S_MK, 8'h00);
		op(S_EI, 8'h00);
		op(S_DI, 8'h00);
		chk(mask, 8'h00);
		for (i = 0; i < 12; i = i + 1)
		begin
			p = (i % 6) + 1;
			p = {2'b00, i > 5, p[2], p[1], i > 5, i > 5, p[0]};
			op(S_DI, 8'h00);
			op(S_PR, p);
			op(S_MK, 8'h3f);
			op(S_FL, 8'h3f);
			op(S_EI, 8'h00);
			op(S_FE, 8'h00);
			wait_busy(1'b1);
			chk({5'h00, lvl}, {5'h00, win(p)});
			chk({vh, vl}, {win(p), 1'b0, win(p), 1'b1});
			chk(flags, 8'h3f & ~(8'h01 << win(p)));
			chk(mask & 8'h80, 8'h00);
			wait_busy(1'b0);
			op(S_RET, 8'h00);
			chk(mask & 8'h80, 8'h80);
		end
		op(S_DI, 8'h00);
		@(posedge core_clk) #1;
		chk({7'h00, int_pending}, 8'h00);
		op(S_MK, 8'h08);
		op(S_FL, 8'h3f);
		op(S_EI, 8'h00);
		op(S_FE, 8'h00);
		wait_busy(1'b1);
		chk({5'h00, lvl}, 8'h03);
		chk(flags, 8'h37);
		wait_busy(1'b0);
		op(S_FL, 8'h00);
		@(posedge core_clk);
		int_req <= 6'h10;
		pin_a <= 1'b0;
		pin_b <= 1'b0;
		@(posedge core_clk);
		int_req <= 6'h00;
		repeat (4) @(posedge core_clk);
		op(S_FE, 8'h00);
		@(posedge core_clk) #1;
		chk(flags, 8'h15);
		pin_case(8'h80, 1'b1, 8'h84);
		pin_case(8'h80, 1'b0, 8'h81);
		pin_case(8'h40, 1'b1, 8'h41);
		pin_case(8'h40, 1'b0, 8'h44);
		pin_case(8'hc0, 1'b1, 8'hc5);
		// Nesting: level 0 is served, then level 3 preempts after the mask drops level 0
		op(S_PR, 8'h28);
		op(S_MK, 8'h09);
		op(S_FL, 8'h01);
		op(S_EI, 8'h00);
		op(S_FE, 8'h00);
		wait_busy(1'b1);
		chk({vh, vl}, 8'h01);
		wait_busy(1'b0);
		op(S_MK, 8'h08);
		op(S_FL, 8'h08);
		op(S_EI, 8'h00);
		op(S_FE, 8'h00);
		wait_busy(1'b1);
		chk({5'h00, lvl}, 8'h03);
		chk({vh, vl}, 8'h67);
		wait_busy(1'b0);
		op(S_DI, 8'h00);
		op(S_MK, 8'h09);
		op(S_RET, 8'h00);
		chk(mask, 8'h89);
		// Reset in mid-run: flags go back to zero and refuse writes until an enable op
		@(posedge core_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		#1;
		chk(mask & 8'h80, 8'h00);
		chk(flags, 8'h00);
		op(S_FL, 8'h3f);
		chk(flags, 8'h00);
		test_done;
	end
endmodule // six_level_interrupt_controller_tb
